//--- hw/device_status_register.sv
// Register access over APB and the address map were decided locally.
`timescale 1ns/100ps
// Behaviour
// (RULE_01) Bit 0 set means full duplex, clear means half duplex.
// (RULE_02) Duplex comes from auto-negotiation or from software setting.
// (RULE_03) Serial mode with auto-negotiation: bit 1 shows negotiated link.
// (RULE_04) Serial mode with forced link: bit 1 mirrors force-link control.
// (RULE_05) Internal PHY mode: bit 1 follows internal link signal.
// (RULE_06) Bits 3:2 give port function number, zero for single port.
// (RULE_07) Bit 4 set after XOFF with symmetric flow control, full duplex.
// (RULE_08) Bit 4 clears on pause timer expiry or XON.
// (RULE_09) Bit 5 set in serial interface mode, zero for PHY mode.
// (RULE_10) Bits 7:6: 00 10M, 01 100M, 1x 1000M.
// (RULE_11) Speed forced, auto-detected once after link, or PHY given.
// (RULE_12) Speed field not meaningful in serial interface mode.
// (RULE_13) Writing speed-check bit runs detection, result in bits 9:8.
// (RULE_14) Bit 11 follows the 66 MHz enable pin.
// (RULE_15) Bit 12 set when 64-bit request seen at bus init.
// (RULE_16) Bit 13 set in extended bus mode, clear in conventional mode.
// (RULE_17) Bits 15:14 give extended bus speed range, valid in that mode.
// (RULE_18) Status is read-only at offset 0x8.
// (RULE_19) Bit 10 and 31:16 read zero; writes to status ignored.
`include "dev_status_defines.svh"

module device_status_register
  import dev_status_pkg::*;
#(
  parameter logic [1:0] PORT_FUNCTION = 2'h0,
  parameter bit HAS_MODE_INPUT = 1'b1
) (
  input wire logic clock_in, // 125 MHz clock
  input wire logic nrst_in, // Sync reset, active low
  input wire logic ce_in, // Clock enable, freezes state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic an_link_ok_in, // Auto-negotiated link valid
  input wire logic an_duplex_in, // Auto-negotiated duplex
  input wire logic phy_link_in, // Internal PHY link signal
  input wire logic [1:0] phy_speed_in, // PHY speed indication
  input wire logic asd_valid_in, // Speed detector result valid
  input wire logic [1:0] asd_speed_in, // Speed detector result
  input wire logic xoff_rx_in, // XOFF frame received, pulse
  input wire logic xon_rx_in, // XON frame received, pulse
  input wire logic pause_expired_in, // Pause timer expired, pulse
  input wire logic sym_fc_in, // Symmetric flow control enabled
  input wire logic serial_interface_mode_pin, // Serial interface strap
  input wire logic bus_66mhz_enable_pin, // 66 MHz bus pin
  input wire logic req64_n_in, // 64-bit request, active low
  input wire logic bus_init_in, // Bus initialisation window
  input wire logic extended_bus_mode_flag_in, // Extended bus mode strap
  input wire logic [1:0] pcix_speed_in, // Extended bus speed range strap
  output logic asd_start_out, // Speed detection start pulse
  output logic irq_out // Interrupt, active high level
);
  // ==========================================================
  // Registers
  logic [`CT_WIDTH-1:0] control_r;
  logic [`IRQ_WIDTH-1:0] irq_status_r;
  logic [`IRQ_WIDTH-1:0] irq_mask_r;
  logic duplex_full_flag_r;
  logic link_up_flag_r;
  logic serial_interface_mode_flag_r;
  logic [1:0] speed_r;
  logic speed_locked_r;
  logic [1:0] detected_speed_value_r;
  logic asd_pending_r;
  logic wide_host_bus_flag_r;
  logic extended_bus_mode_flag_r;
  logic [1:0] extended_bus_speed_range_r;
  logic link_prev_r;
  logic transmit_paused_flag_prev_r;
  logic [`IRQ_WIDTH-1:0] irq_event;
  logic [31:0] status_word;
  logic transmit_paused_flag;
  logic host_bus_66mhz_flag;
  logic serial_mode_sync;
  logic phy_link_sync;
  logic req64_n_sync;
  logic wr_en;

  function automatic logic addr_hit(input logic [`ADDR_W-1:0] a);
    addr_hit = (a == `DEVICE_STATUS_ADDR) || (a == `CONTROL_ADDR) ||
               (a == `IRQ_STATUS_ADDR) || (a == `IRQ_MASK_ADDR);
  endfunction : addr_hit

  // ==========================================================
  // Pin synchronisers and pause tracker
  pin_sync3 u_sync_mode (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .pin_in(serial_interface_mode_pin),
    .level_out(serial_mode_sync)
  );
  pin_sync3 u_sync_66 (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .pin_in(bus_66mhz_enable_pin),
    .level_out(host_bus_66mhz_flag)
  );
  pin_sync3 u_sync_req64 (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .pin_in(req64_n_in),
    .level_out(req64_n_sync)
  );
  pin_sync3 u_sync_link (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .pin_in(phy_link_in),
    .level_out(phy_link_sync)
  );

  pause_tracker u_pause (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .xoff_rx_in(xoff_rx_in),
    .xon_rx_in(xon_rx_in),
    .pause_expired_in(pause_expired_in),
    .sym_fc_in(sym_fc_in),
    .full_duplex_in(duplex_full_flag_r),
    .paused_out(transmit_paused_flag)
  );

  // ==========================================================
  // APB access strobes; one wait state before pready
  assign wr_en = psel && penable && pwrite && pready;

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (ce_in) begin
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        pslverr <= !addr_hit(paddr);
        prdata <= 32'h0;
        if (!pwrite) begin
          case (paddr)
            // (RULE_18) status readback
            `DEVICE_STATUS_ADDR: prdata <= status_word;
            `CONTROL_ADDR: prdata <= {{(32-`CT_WIDTH){1'b0}}, control_r};
            `IRQ_STATUS_ADDR: prdata <= {{(32-`IRQ_WIDTH){1'b0}}, irq_status_r};
            `IRQ_MASK_ADDR: prdata <= {{(32-`IRQ_WIDTH){1'b0}}, irq_mask_r};
            default: prdata <= 32'h0;
          endcase
        end
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Control and mask registers; status writes fall through
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      control_r <= '0;
      irq_mask_r <= '0;
    end else if (ce_in) begin
      // Check bit self-clears so each write of one starts one detection
      control_r[`CT_ASD_CHECK] <= 1'b0;
      // (RULE_19) status writes ignored
      if (wr_en && paddr == `CONTROL_ADDR) begin
        control_r <= pwdata[`CT_WIDTH-1:0];
      end
      if (wr_en && paddr == `IRQ_MASK_ADDR) begin
        irq_mask_r <= pwdata[`IRQ_WIDTH-1:0];
      end
    end
  end

  // ==========================================================
  // Link, duplex and mode
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      duplex_full_flag_r <= 1'b0;
      link_up_flag_r <= 1'b0;
      serial_interface_mode_flag_r <= 1'b0;
    end else if (ce_in) begin
      // (RULE_09) mode flag from strap
      serial_interface_mode_flag_r <= HAS_MODE_INPUT ? serial_mode_sync : 1'b0;
      // (RULE_02) duplex source select
      if (control_r[`CT_SW_DUPLEX]) begin
        duplex_full_flag_r <= control_r[`CT_DUPLEX_VAL];
      end else begin
        // (RULE_01) duplex bit value
        duplex_full_flag_r <= an_duplex_in;
      end
      if (serial_interface_mode_flag_r) begin
        if (control_r[`CT_FORCE_LINK]) begin
          // (RULE_04) mirror force control
          link_up_flag_r <= 1'b1;
        end else if (control_r[`CT_AUTONEG]) begin
          // (RULE_03) negotiated link
          link_up_flag_r <= an_link_ok_in;
        end else begin
          link_up_flag_r <= 1'b0;
        end
      end else begin
        // (RULE_05) follow internal link
        link_up_flag_r <= phy_link_sync;
      end
    end
  end

  // ==========================================================
  // Speed selection; auto mode latches once per link assertion
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      speed_r <= `SPEED_10;
      speed_locked_r <= 1'b0;
    end else if (ce_in) begin
      // (RULE_11) speed source select
      if (control_r[`CT_FORCE_SPEED]) begin
        speed_r <= control_r[`CT_SPD_HI:`CT_SPD_LO];
      end else if (control_r[`CT_AUTO_SPEED]) begin
        if (!phy_link_sync) begin
          speed_locked_r <= 1'b0;
        end else if (!speed_locked_r && asd_valid_in) begin
          speed_r <= asd_speed_in;
          speed_locked_r <= 1'b1;
        end
      end else begin
        // (RULE_10) PHY encoding passed as is
        speed_r <= phy_speed_in;
      end
    end
  end

  // ==========================================================
  // Diagnostic speed detection
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      detected_speed_value_r <= `SPEED_10;
      asd_pending_r <= 1'b0;
      asd_start_out <= 1'b0;
    end else if (ce_in) begin
      // (RULE_13) start and capture
      asd_start_out <= control_r[`CT_ASD_CHECK];
      if (control_r[`CT_ASD_CHECK]) begin
        asd_pending_r <= 1'b1;
      end else if (asd_pending_r && asd_valid_in) begin
        detected_speed_value_r <= asd_speed_in;
        asd_pending_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Host bus straps; bus width caught only in init window
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      wide_host_bus_flag_r <= 1'b0;
      extended_bus_mode_flag_r <= 1'b0;
      extended_bus_speed_range_r <= 2'h0;
    end else if (ce_in) begin
      if (bus_init_in) begin
        // (RULE_15) 64-bit request at init
        wide_host_bus_flag_r <= !req64_n_sync;
        // (RULE_16) extended mode capture
        extended_bus_mode_flag_r <= extended_bus_mode_flag_in;
        // (RULE_17) speed range capture
        extended_bus_speed_range_r <= pcix_speed_in;
      end
    end
  end

  // ==========================================================
  // Status word assembly
  always_comb begin
    // (RULE_19) reserved bits zero
    status_word = 32'h0;
    status_word[`ST_DUPLEX] = duplex_full_flag_r;
    status_word[`ST_LINK] = link_up_flag_r;
    // (RULE_06) function number
    status_word[`ST_FUNC_HI:`ST_FUNC_LO] = PORT_FUNCTION;
    status_word[`ST_TRANSMIT_PAUSED_FLAG] = transmit_paused_flag;
    status_word[`ST_SERIAL] = serial_interface_mode_flag_r;
    // (RULE_12) speed left as is in serial mode
    status_word[`ST_SPD_HI:`ST_SPD_LO] = speed_r;
    status_word[`ST_ASD_HI:`ST_ASD_LO] = detected_speed_value_r;
    // (RULE_14) 66 MHz pin
    status_word[`ST_B66] = host_bus_66mhz_flag;
    status_word[`ST_WIDE_HOST_BUS_FLAG] = wide_host_bus_flag_r;
    status_word[`ST_PCIX] = extended_bus_mode_flag_r;
    status_word[`ST_XSPD_HI:`ST_XSPD_LO] = extended_bus_speed_range_r;
  end

  // ==========================================================
  // Interrupts: sticky events, write one to clear, set wins
  always_comb begin
    irq_event = '0;
    irq_event[`IRQ_LINK_CHG] = link_up_flag_r != link_prev_r;
    irq_event[`IRQ_TRANSMIT_PAUSED_FLAG_CHG] = transmit_paused_flag != transmit_paused_flag_prev_r;
    irq_event[`IRQ_ASD_DONE] = asd_pending_r && asd_valid_in;
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      irq_status_r <= '0;
      link_prev_r <= 1'b0;
      transmit_paused_flag_prev_r <= 1'b0;
      irq_out <= 1'b0;
    end else if (ce_in) begin
      link_prev_r <= link_up_flag_r;
      transmit_paused_flag_prev_r <= transmit_paused_flag;
      if (wr_en && paddr == `IRQ_STATUS_ADDR) begin
        irq_status_r <= (irq_status_r & ~pwdata[`IRQ_WIDTH-1:0]) | irq_event;
      end else begin
        irq_status_r <= irq_status_r | irq_event;
      end
      irq_out <= |(irq_status_r & irq_mask_r);
    end
  end
endmodule : device_status_register

//--- hw/pause_tracker.sv
`timescale 1ns/100ps
// ==========================================================
// Transmit pause state: set by XOFF in symmetric full duplex
module pause_tracker
  import dev_status_pkg::*;
(
  input wire logic clock_in, // Clock
  input wire logic nrst_in, // Sync reset, active low
  input wire logic ce_in, // Clock enable
  input wire logic xoff_rx_in, // XOFF frame received, pulse
  input wire logic xon_rx_in, // XON frame received, pulse
  input wire logic pause_expired_in, // Pause timer expired, pulse
  input wire logic sym_fc_in, // Symmetric flow control enabled
  input wire logic full_duplex_in, // Link in full duplex
  output logic paused_out // Transmit paused
);
  pause_state_t state_r;

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      state_r <= pause_idle;
    end else if (ce_in) begin
      case (state_r)
        // (RULE_07) enter pause
        pause_idle: begin
          if (xoff_rx_in && sym_fc_in && full_duplex_in) begin
            state_r <= pause_held;
          end
        end
        // (RULE_08) leave pause
        pause_held: begin
          if (xon_rx_in || pause_expired_in || !full_duplex_in) begin
            state_r <= pause_idle;
          end
        end
        default: begin
          state_r <= pause_idle;
        end
      endcase
    end
  end

  assign paused_out = (state_r == pause_held);
endmodule : pause_tracker

//--- hw/pin_sync3.sv
`timescale 1ns/100ps
// ==========================================================
// Three-stage synchroniser, change accepted when stages 2 and 3 agree
module pin_sync3 (
  input wire logic clock_in, // Clock
  input wire logic nrst_in, // Sync reset, active low
  input wire logic ce_in, // Clock enable
  input wire logic pin_in, // Asynchronous pin
  output logic level_out // Filtered level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_out <= 1'b0;
    end else if (ce_in) begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_out <= s3_r;
      end
    end
  end
endmodule : pin_sync3

//--- pkg/dev_status_defines.svh
`ifndef DEV_STATUS_DEFINES_SVH
`define DEV_STATUS_DEFINES_SVH

// ==========================================================
// Register map
`define DEVICE_STATUS_ADDR 12'h008
`define CONTROL_ADDR 12'h000
`define IRQ_STATUS_ADDR 12'h100
`define IRQ_MASK_ADDR 12'h104
`define ADDR_W 12

// ==========================================================
// Status field positions
`define ST_DUPLEX 0
`define ST_LINK 1
`define ST_FUNC_LO 2
`define ST_FUNC_HI 3
`define ST_TRANSMIT_PAUSED_FLAG 4
`define ST_SERIAL 5
`define ST_SPD_LO 6
`define ST_SPD_HI 7
`define ST_ASD_LO 8
`define ST_ASD_HI 9
`define ST_B66 11
`define ST_WIDE_HOST_BUS_FLAG 12
`define ST_PCIX 13
`define ST_XSPD_LO 14
`define ST_XSPD_HI 15

// ==========================================================
// Control register bits (own register)
`define CT_FORCE_LINK 0
`define CT_FORCE_SPEED 1
`define CT_AUTO_SPEED 2
`define CT_SW_DUPLEX 3
`define CT_AUTONEG 4
`define CT_DUPLEX_VAL 5
`define CT_SPD_LO 6
`define CT_SPD_HI 7
`define CT_ASD_CHECK 8
`define CT_WIDTH 9

// ==========================================================
// Interrupt bits
`define IRQ_LINK_CHG 0
`define IRQ_TRANSMIT_PAUSED_FLAG_CHG 1
`define IRQ_ASD_DONE 2
`define IRQ_WIDTH 3

`define SPEED_10 2'h0
`define SPEED_100 2'h1
`define SPEED_1000 2'h2

`endif

//--- pkg/dev_status_pkg.sv
package dev_status_pkg;
  typedef logic [1:0] speed_t;
  typedef enum logic [1:0] {
    pause_idle,
    pause_held
  } pause_state_t;
endpackage : dev_status_pkg

//--- test/device_status_register_properties.sv
`timescale 1ns/100ps
// ==========================================================
// Port checks for the status register block
module device_status_register_properties #(
  parameter logic [1:0] PORT_FUNCTION = 2'h0
) (
  input wire logic clock_in, // Clock
  input wire logic nrst_in, // Sync reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic asd_start_out // Speed check start
);
  logic done;
  logic mapped;
  logic st_rd;
  assign done = psel & penable & pready;
  assign mapped = (paddr == 12'h000) | (paddr == 12'h008) |
                  (paddr == 12'h100) | (paddr == 12'h104);
  assign st_rd = done & ~pwrite & (paddr == 12'h008);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);
  a_ready_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("pready missing one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_reserved_zero: assert property (st_rd |-> prdata[31:16] == 16'h0 && !prdata[10])
    else $error("reserved status bits not zero");
  a_func_number: assert property (st_rd |-> prdata[3:2] == PORT_FUNCTION)
    else $error("function number wrong");
  a_status_noerr: assert property (done && paddr == 12'h008 |-> !pslverr)
    else $error("status access flagged as error");
  a_unmapped_err: assert property (done && !mapped |->
    pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_asd_kick: assert property (done && pwrite && paddr == 12'h000 && pwdata[8]
    |-> ##[0:2] asd_start_out)
    else $error("speed check not started");
  a_asd_single: assert property (asd_start_out |=> !asd_start_out)
    else $error("speed check start longer than one cycle");
endmodule : device_status_register_properties

bind device_status_register device_status_register_properties #(
  .PORT_FUNCTION(PORT_FUNCTION)
) u_props (
  .clock_in(clock_in),
  .nrst_in(nrst_in),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .asd_start_out(asd_start_out)
);

//--- test/device_status_register_tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module device_status_register_tb_top;
  import dev_status_pkg::*;
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, asd_start_out, irq_out;
  logic an_link_ok_in = 1'b0, an_duplex_in = 1'b0, phy_link_in = 1'b0;
  logic [1:0] phy_speed_in = 2'h0, asd_speed_in = 2'h0, pcix_speed_in = 2'h0;
  logic [3:0] ev = 4'h0;
  logic bus_init_in = 1'b1;
  logic sym_fc_in = 1'b1, ser_pin = 1'b0, b66_pin = 1'b0, req64_n_in = 1'b1, extended_bus_mode_flag_in = 1'b0;
  logic [31:0] rdv;
  logic erv, kick;
  int fails = 0, n_compared = 0, cycles = 0;

  device_status_register u_dut (.clock_in(clock_in), .nrst_in(nrst_in), .ce_in(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .an_link_ok_in(an_link_ok_in),
    .an_duplex_in(an_duplex_in), .phy_link_in(phy_link_in), .phy_speed_in(phy_speed_in),
    .asd_valid_in(ev[3]), .asd_speed_in(asd_speed_in), .xoff_rx_in(ev[0]),
    .xon_rx_in(ev[1]), .pause_expired_in(ev[2]), .sym_fc_in(sym_fc_in),
    .serial_interface_mode_pin(ser_pin), .bus_66mhz_enable_pin(b66_pin),
    .req64_n_in(req64_n_in), .bus_init_in(bus_init_in), .extended_bus_mode_flag_in(extended_bus_mode_flag_in),
    .pcix_speed_in(pcix_speed_in), .asd_start_out(asd_start_out), .irq_out(irq_out));

  always #4 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    if (asd_start_out === 1'b1) begin
      kick <= 1'b1;
    end
  end
  // Whole run is a few hundred cycles; the ceiling only catches a hang
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end

  task automatic conclude;
    if (fails == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  task automatic cyc(input int k);
    repeat (k) @(posedge clock_in);
  endtask : cyc

  // ==========================================================
  // APB master: one idle edge after each transfer so calls may follow at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    cyc(1);
    penable <= 1'b1;
    // Only the global cycle ceiling ends a wait that never completes
    do begin
      cyc(1);
    end while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    cyc(1);
  endtask : apb

  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    cyc(1);
    ev <= 4'h0;
    cyc(3);
  endtask : pulse

  // ==========================================================
  // Scenarios
  task automatic t_bus;
    logic [1:0] s;
    b66_pin <= 1'b1;
    req64_n_in <= 1'b0;
    extended_bus_mode_flag_in <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      s = i[1:0];
      pcix_speed_in <= s;
      cyc(6);
      apb(1'b0, 12'h008, 32'h0);
      `CHK(rdv[15:14], s)
      `CHK(rdv[13:11], 3'h7)
    end
    `CHK({rdv[10], rdv[5:2]}, 5'h0)
    // Straps must hold their captured values once the init window closes
    bus_init_in <= 1'b0;
    b66_pin <= 1'b0;
    req64_n_in <= 1'b1;
    extended_bus_mode_flag_in <= 1'b0;
    pcix_speed_in <= 2'h0;
    cyc(6);
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rdv[15:11], 5'h16)
    bus_init_in <= 1'b1;
    cyc(6);
    apb(1'b1, 12'h008, 32'hFFFFFFFF);
    `CHK(erv, 1'b0)
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rdv[31:10], 22'h0)
    apb(1'b0, 12'h0FC, 32'h0);
    `CHK({erv, rdv}, 33'h100000000)
  endtask : t_bus

  task automatic t_phy;
    logic [1:0] s;
    phy_link_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      s = i[1:0];
      phy_speed_in <= s;
      cyc(6);
      apb(1'b0, 12'h008, 32'h0);
      `CHK(rdv[1], 1'b1)
      `CHK(rdv[7], s[1])
      if (!s[1]) `CHK(rdv[6], s[0])
    end
    apb(1'b1, 12'h000, 32'h00000042);
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rdv[7:6], 2'h1)
    phy_link_in <= 1'b0;
    an_duplex_in <= 1'b1;
    apb(1'b1, 12'h000, 32'h00000028);
    cyc(6);
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rdv[1:0], 2'h1)
    apb(1'b1, 12'h000, 32'h00000008);
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rdv[0], 1'b0)
    apb(1'b1, 12'h000, 32'h00000010);
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rdv[0], 1'b1)
  endtask : t_phy

  task automatic t_serial;
    ser_pin <= 1'b1;
    an_link_ok_in <= 1'b1;
    cyc(6);
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rdv[5:4], 2'h2)
    `CHK(rdv[1], 1'b1)
    an_link_ok_in <= 1'b0;
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rdv[1], 1'b0)
    apb(1'b1, 12'h000, 32'h00000001);
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rdv[1], 1'b1)
    apb(1'b1, 12'h000, 32'h00000000);
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rdv[1], 1'b0)
    ser_pin <= 1'b0;
    cyc(6);
  endtask : t_serial

  task automatic t_pause;
    apb(1'b1, 12'h000, 32'h00000028);
    apb(1'b1, 12'h104, 32'h00000002);
    apb(1'b1, 12'h100, 32'h00000007);
    pulse(0);
    apb(1'b0, 12'h008, 32'h0);
    `CHK({rdv[4], irq_out}, 2'h3)
    apb(1'b1, 12'h100, 32'h00000002);
    cyc(1);
    `CHK(irq_out, 1'b0)
    pulse(1);
    apb(1'b0, 12'h008, 32'h0);
    `CHK({rdv[4], irq_out}, 2'h1)
    apb(1'b1, 12'h104, 32'h00000000);
    cyc(1);
    `CHK(irq_out, 1'b0)
    pulse(0);
    pulse(2);
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rdv[4], 1'b0)
    apb(1'b1, 12'h000, 32'h00000008);
    pulse(0);
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rdv[4], 1'b0)
  endtask : t_pause

  task automatic t_asd;
    kick = 1'b0;
    asd_speed_in <= 2'h1;
    apb(1'b1, 12'h000, 32'h00000104);
    cyc(3);
    `CHK(kick, 1'b1)
    pulse(3);
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rdv[9:8], 2'h1)
    // Auto speed stays on: first result after link up locks, later ones are ignored
    phy_link_in <= 1'b1;
    asd_speed_in <= 2'h2;
    cyc(6);
    pulse(3);
    asd_speed_in <= 2'h1;
    pulse(3);
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rdv[7:6], 2'h2)
  endtask : t_asd

  initial begin
    cyc(20);
    nrst_in <= 1'b1;
    cyc(1);
    t_bus();
    t_phy();
    t_serial();
    t_pause();
    t_asd();
    conclude();
  end
endmodule : device_status_register_tb_top
